// >>> otp_store_consts.svh
// offsets, field positions, reset values and timing counts of the parameter store
// assumes inclusion by bare name from every design file that needs them
`ifndef OTP_STORE_CONSTS_SVH
`define OTP_STORE_CONSTS_SVH
// byte addresses of the eight store bytes
`define ADDR_CLOCK_CURRENT_TRIM   3'h0
`define ADDR_THERMAL_BANDGAP_TRIM 3'h1
`define ADDR_NODE_ID_CONFIG       3'h2
`define ADDR_COIL_CURRENT_CONFIG  3'h3
`define ADDR_SPEED_CONFIG         3'h4
`define ADDR_SAFE_POS_HI_RAMP     3'h5
`define ADDR_SAFE_POS_LO          3'h6
`define ADDR_STEP_LOCK_CONFIG     3'h7
`define ADDR_LAST_TRIM            3'h1
// field positions
`define POS_ID_SWAP       7
`define POS_PIN_ID_HI     6
`define POS_PIN_ID_LO     4
`define POS_SHAFT         4
`define POS_RES_HI        3
`define POS_RES_LO        2
`define POS_TRIM_LOCK     1
`define POS_GLOBAL_LOCK   0
// byte node_id_config bits 6:4 are never stored: they mirror the pins
`define NODE_STORE_MASK   8'h8f
// delivery contents of byte thermal_bandgap_trim and byte step_lock_config
`define RST_THERMAL_BYTE  8'h80
`define RST_STEP_LOCK     8'h02
// safe target value that turns secure positioning off
`define SAFE_TARGET_OFF   11'h400
// timing
`define CLK_MHZ           125
`define ZAP_TIME_US       100
`endif

// >>> otp_store_pkg.sv
// types shared by the parameter store and its helpers
// assumes nothing beyond a SystemVerilog compiler
package otp_store_pkg;
	// command codes arriving from the frame decoder
	typedef enum logic [1:0] {
		burn_byte_cmd        = 2'h0,
		fetch_nvm_cmd        = 2'h1,
		write_motion_cfg_cmd = 2'h2,
		restore_defaults_cmd = 2'h3
	} cmd_op_t;
	// gray coded along idle -> zap -> idle and idle -> load -> idle
	typedef enum logic [1:0] {
		st_idle = 2'h0,
		st_zap  = 2'h1,
		st_load = 2'h2
	} state_t;
	// step resolution decode
	typedef enum logic [1:0] {
		res_half      = 2'h0,
		res_quarter   = 2'h1,
		res_eighth    = 2'h2,
		res_sixteenth = 2'h3
	} microstep_res_t;
	// working-ram motion parameters, overridable over the bus
	typedef struct packed {
		logic [3:0]     irun;
		logic [3:0]     ihold;
		logic [3:0]     vmax;
		logic [3:0]     vmin;
		logic [10:0]    safe_target;
		logic           shaft;
		logic [3:0]     acc;
		microstep_res_t microstep_res;
	} motion_cfg_t;
endpackage

// >>> pin_sync.sv
// three-stage synchroniser for the address pins
// assumes pins change slowly compared with the core clock
`timescale 1ns/1ns
module pin_sync #(
	parameter int W = 3
) (
	// clock and reset
	input  wire logic         clk_in,
	input  wire logic         rst_b_in,
	// raw pins and clean copy
	input  wire logic [W-1:0] pin_in,
	output logic      [W-1:0] pin_out
);
	logic [W-1:0] s1_q;
	logic [W-1:0] s2_q;
	logic [W-1:0] s3_q;
	// s1 feeds s2 only; a change counts once s2 and s3 agree
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			s1_q    <= '0;
			s2_q    <= '0;
			s3_q    <= '0;
			pin_out <= '0;
		end else begin
			s1_q <= pin_in;
			s2_q <= s1_q;
			s3_q <= s2_q;
			if (s2_q == s3_q) pin_out <= s3_q;
		end
	end
endmodule

// >>> coil_current_lut.sv
// coil current code to amplitude in milliamps
// assumes a registered code at its input; output is registered
`timescale 1ns/1ns
module coil_current_lut (
	// clock and reset
	input  wire logic       clk_in,
	input  wire logic       rst_b_in,
	// code and amplitude
	input  wire logic [3:0] code_in,
	output logic      [9:0] ma_out
);
	// one table serves run and standstill codes
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			ma_out <= 10'h03b;
		end else begin
			case (code_in)
				4'h0: ma_out <= 10'd59;
				4'h1: ma_out <= 10'd71;
				4'h2: ma_out <= 10'd84;
				4'h3: ma_out <= 10'd100;
				4'h4: ma_out <= 10'd119;
				4'h5: ma_out <= 10'd141;
				4'h6: ma_out <= 10'd168;
				4'h7: ma_out <= 10'd200;
				4'h8: ma_out <= 10'd238;
				4'h9: ma_out <= 10'd283;
				4'ha: ma_out <= 10'd336;
				4'hb: ma_out <= 10'd400;
				4'hc: ma_out <= 10'd476;
				4'hd: ma_out <= 10'd566;
				4'he: ma_out <= 10'd673;
				default: ma_out <= 10'd800;
			endcase
		end
	end
endmodule

// >>> otp_param_store.sv
// one-time-programmable parameter store with lock bits and working-ram copy
// assumes a frame decoder on the same clock presenting one command per handshake
//
// Behaviour
// - eight store bytes, addresses clock_current_trim to step_lock_config
// - blank bits read zero, zapping sets one
// - bits already one are never zapped again
// - one byte programmed per program command
// - global lock blocks zapping of all bytes
// - trim lock blocks zapping of bytes clock_current_trim-thermal_bandgap_trim
// - trim bytes and trim lock come preprogrammed
// - read of byte node_id_config shows live pins
// - zapped bits act after read, restore, power-up
// - ram parameters overridable except node bits
// - node id from programmable and pin bits
// - swap bit exchanges the two id groups
// - seven-bit id gives 128 nodes
// - run code selects sixteen currents, 59-800 mA
// - standstill code uses same current table
// - stopped motor drops to standstill current
// - resolution code selects half to sixteenth
// - shaft bit selects rotation direction
// - safe target 0x400 disables secure positioning
// - restore reloads ram, positions untouched
`timescale 1ns/1ns
`include "otp_store_consts.svh"
module otp_param_store #(
	parameter int         ZAP_TIME_US = `ZAP_TIME_US,
	parameter logic [7:0] CAL_BYTE0   = 8'h00,
	parameter logic [7:0] CAL_BYTE1   = `RST_THERMAL_BYTE
) (
	// clock and reset
	input  wire logic                        core_clk_in,
	input  wire logic                        rst_b_in,
	// command from the frame decoder
	input  wire logic                        cmd_valid_in,
	output logic                             cmd_ready_out,
	input  wire otp_store_pkg::cmd_op_t      cmd_op_in,
	input  wire logic [2:0]                  cmd_addr_in,
	input  wire logic [7:0]                  cmd_data_in,
	input  wire otp_store_pkg::motion_cfg_t  cmd_cfg_in,
	// answers
	output logic                             rd_valid_out,
	output logic [7:0]                       rd_data_out,
	output logic                             burn_refused_out,
	output logic                             burn_done_out,
	// pins and motor state
	input  wire logic [2:0]                  pin_id_bits_in,
	input  wire logic                        motor_stopped_in,
	// active parameters
	output otp_store_pkg::motion_cfg_t       active_cfg_out,
	output logic [6:0]                       node_id_out,
	output logic [3:0]                       coil_code_out,
	output logic [9:0]                       coil_ma_out,
	output logic                             safe_pos_en_out,
	output logic [3:0]                       clock_trim_out,
	output logic [3:0]                       current_ref_trim_out,
	output logic [2:0]                       thermal_trim_out,
	output logic [3:0]                       bandgap_trim_out
);
	// zap pulse length in cycles, at least one
	localparam int ZAP_CYC_RAW = ZAP_TIME_US * `CLK_MHZ;
	localparam int ZAP_CYC     = (ZAP_CYC_RAW < 1) ? 1 : ZAP_CYC_RAW;

	logic                       rst_s1_q;
	logic                       rst_b;
	logic [2:0]                 pin_id_bits;
	logic [7:0]                 nvm_q [8];
	otp_store_pkg::state_t      state_q;
	logic [23:0]                zap_cnt_q;
	logic [2:0]                 zap_addr_q;
	logic [7:0]                 zap_bits_q;
	logic                       cmd_take;
	logic                       burn_take;
	logic                       locked;
	logic [7:0]                 zap_bits_d;
	otp_store_pkg::motion_cfg_t ram_cfg_q;
	otp_store_pkg::motion_cfg_t nvm_cfg;
	logic                       id_swap_sel_q;
	logic [3:0]                 prog_node_bits_q;
	logic [7:0]                 trim0_q;
	logic [7:0]                 trim1_q;
	logic [63:0]                nvm_flat;

	// reset release through two flops
	always_ff @(posedge core_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			rst_s1_q <= 1'b0;
			rst_b    <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_b    <= rst_s1_q;
		end
	end

	// address pins come from outside the clock domain
	pin_sync #(.W(3)) u_pin_sync (
		.clk_in   (core_clk_in),
		.rst_b_in (rst_b),
		.pin_in   (pin_id_bits_in),
		.pin_out  (pin_id_bits)
	);

	// commands are only taken while idle; zapping is slow and not queued
	assign cmd_ready_out = (state_q == otp_store_pkg::st_idle);
	assign cmd_take      = cmd_valid_in && cmd_ready_out;
	assign burn_take     = cmd_take && (cmd_op_in == otp_store_pkg::burn_byte_cmd);

	// lock check against the stored lock bits
	always_comb begin
		locked = nvm_q[`ADDR_STEP_LOCK_CONFIG][`POS_GLOBAL_LOCK];
		if (cmd_addr_in <= `ADDR_LAST_TRIM) begin
			locked = locked | nvm_q[`ADDR_STEP_LOCK_CONFIG][`POS_TRIM_LOCK];
		end
	end

	// only bits that are zero and asked to be one are zapped
	always_comb begin
		zap_bits_d = cmd_data_in & ~nvm_q[cmd_addr_in];
		if (cmd_addr_in == `ADDR_NODE_ID_CONFIG) begin
			zap_bits_d = zap_bits_d & `NODE_STORE_MASK;
		end
	end

	// sequencer: power-up load, zap timing, reload on read or restore
	always_ff @(posedge core_clk_in or negedge rst_b) begin
		if (!rst_b) begin
			state_q <= otp_store_pkg::st_load;
		end else begin
			case (state_q)
				otp_store_pkg::st_idle: begin
					if (burn_take && !locked) begin
						state_q <= otp_store_pkg::st_zap;
					end else if (cmd_take && (cmd_op_in == otp_store_pkg::fetch_nvm_cmd ||
							cmd_op_in == otp_store_pkg::restore_defaults_cmd)) begin
						state_q <= otp_store_pkg::st_load;
					end
				end
				otp_store_pkg::st_zap: begin
					if (zap_cnt_q == 24'h000000) state_q <= otp_store_pkg::st_idle;
				end
				default: state_q <= otp_store_pkg::st_idle;
			endcase
		end
	end

	// zap pulse counter and latched target
	always_ff @(posedge core_clk_in or negedge rst_b) begin
		if (!rst_b) begin
			zap_cnt_q  <= 24'h000000;
			zap_addr_q <= 3'h0;
			zap_bits_q <= 8'h00;
		end else if (burn_take && !locked) begin
			zap_cnt_q  <= 24'(ZAP_CYC - 1);
			zap_addr_q <= cmd_addr_in;
			zap_bits_q <= zap_bits_d;
		end else if (zap_cnt_q != 24'h000000) begin
			zap_cnt_q <= zap_cnt_q - 24'h000001;
		end
	end

	// the store array; bits only ever rise, reset models delivery contents
	always_ff @(posedge core_clk_in or negedge rst_b) begin
		if (!rst_b) begin
			for (int i = 0; i < 8; i++) begin
				nvm_q[i] <= 8'h00;
			end
			nvm_q[`ADDR_CLOCK_CURRENT_TRIM]   <= CAL_BYTE0;
			nvm_q[`ADDR_THERMAL_BANDGAP_TRIM] <= CAL_BYTE1;
			nvm_q[`ADDR_STEP_LOCK_CONFIG]     <= `RST_STEP_LOCK;
		end else if (state_q == otp_store_pkg::st_zap && zap_cnt_q == 24'h000000) begin
			nvm_q[zap_addr_q] <= nvm_q[zap_addr_q] | zap_bits_q;
		end
	end

	// a refused program leaves the store alone and says so for one cycle
	always_ff @(posedge core_clk_in or negedge rst_b) begin
		if (!rst_b) begin
			burn_refused_out <= 1'b0;
			burn_done_out    <= 1'b0;
		end else begin
			burn_refused_out <= burn_take && locked;
			burn_done_out    <= (state_q == otp_store_pkg::st_zap) && (zap_cnt_q == 24'h000000);
		end
	end

	// read answer: byte node_id_config carries the live pins in place of stored bits
	always_ff @(posedge core_clk_in or negedge rst_b) begin
		if (!rst_b) begin
			rd_valid_out <= 1'b0;
			rd_data_out  <= 8'h00;
		end else begin
			rd_valid_out <= cmd_take && (cmd_op_in == otp_store_pkg::fetch_nvm_cmd);
			if (cmd_take && cmd_op_in == otp_store_pkg::fetch_nvm_cmd) begin
				rd_data_out <= nvm_q[cmd_addr_in];
				if (cmd_addr_in == `ADDR_NODE_ID_CONFIG) begin
					rd_data_out[`POS_PIN_ID_HI:`POS_PIN_ID_LO] <= pin_id_bits;
				end
			end
		end
	end

	// store bytes unpacked into the ram layout
	always_comb begin
		nvm_cfg.irun          = nvm_q[`ADDR_COIL_CURRENT_CONFIG][7:4];
		nvm_cfg.ihold         = nvm_q[`ADDR_COIL_CURRENT_CONFIG][3:0];
		nvm_cfg.vmax          = nvm_q[`ADDR_SPEED_CONFIG][7:4];
		nvm_cfg.vmin          = nvm_q[`ADDR_SPEED_CONFIG][3:0];
		nvm_cfg.safe_target   = {nvm_q[`ADDR_SAFE_POS_HI_RAMP][7:5], nvm_q[`ADDR_SAFE_POS_LO]};
		nvm_cfg.shaft         = nvm_q[`ADDR_SAFE_POS_HI_RAMP][`POS_SHAFT];
		nvm_cfg.acc           = nvm_q[`ADDR_SAFE_POS_HI_RAMP][3:0];
		nvm_cfg.microstep_res = otp_store_pkg::microstep_res_t'(
			nvm_q[`ADDR_STEP_LOCK_CONFIG][`POS_RES_HI:`POS_RES_LO]);
	end

	// working ram: loaded from store on load, overwritten by parameter write
	always_ff @(posedge core_clk_in or negedge rst_b) begin
		if (!rst_b) begin
			ram_cfg_q <= '0;
		end else if (state_q == otp_store_pkg::st_load) begin
			ram_cfg_q <= nvm_cfg;
		end else if (cmd_take && cmd_op_in == otp_store_pkg::write_motion_cfg_cmd) begin
			ram_cfg_q <= cmd_cfg_in;
		end
	end

	// node bits and trims follow the store only on load, never a bus write
	always_ff @(posedge core_clk_in or negedge rst_b) begin
		if (!rst_b) begin
			id_swap_sel_q    <= 1'b0;
			prog_node_bits_q <= 4'h0;
			trim0_q          <= 8'h00;
			trim1_q          <= 8'h00;
		end else if (state_q == otp_store_pkg::st_load) begin
			id_swap_sel_q    <= nvm_q[`ADDR_NODE_ID_CONFIG][`POS_ID_SWAP];
			prog_node_bits_q <= nvm_q[`ADDR_NODE_ID_CONFIG][3:0];
			trim0_q          <= nvm_q[`ADDR_CLOCK_CURRENT_TRIM];
			trim1_q          <= nvm_q[`ADDR_THERMAL_BANDGAP_TRIM];
		end
	end

	// node id: pins high and programmable bits low unless swapped
	always_ff @(posedge core_clk_in or negedge rst_b) begin
		if (!rst_b) begin
			node_id_out <= 7'h00;
		end else if (id_swap_sel_q) begin
			node_id_out <= {prog_node_bits_q, pin_id_bits};
		end else begin
			node_id_out <= {pin_id_bits, prog_node_bits_q};
		end
	end

	// coil code drops to standstill when stopped; positions live elsewhere
	always_ff @(posedge core_clk_in or negedge rst_b) begin
		if (!rst_b) begin
			coil_code_out   <= 4'h0;
			safe_pos_en_out <= 1'b0;
		end else begin
			coil_code_out   <= motor_stopped_in ? ram_cfg_q.ihold : ram_cfg_q.irun;
			safe_pos_en_out <= (ram_cfg_q.safe_target != `SAFE_TARGET_OFF);
		end
	end

	// run and standstill share one amplitude table
	coil_current_lut u_coil_lut (
		.clk_in  (core_clk_in),
		.rst_b_in (rst_b),
		.code_in (coil_code_out),
		.ma_out  (coil_ma_out)
	);

	// direction and resolution pass through as decoded fields
	assign active_cfg_out       = ram_cfg_q;
	assign clock_trim_out       = trim0_q[7:4];
	assign current_ref_trim_out = trim0_q[3:0];
	assign thermal_trim_out     = trim1_q[6:4];
	assign bandgap_trim_out     = trim1_q[3:0];

	// helpers for the checks below
	assign nvm_flat = {nvm_q[7], nvm_q[6], nvm_q[5], nvm_q[4],
		nvm_q[3], nvm_q[2], nvm_q[1], nvm_q[0]};

	sequence s_fetch_taken;
		cmd_take && cmd_op_in == otp_store_pkg::fetch_nvm_cmd;
	endsequence

	sequence s_load_then_copy;
		state_q == otp_store_pkg::st_load ##1 ram_cfg_q == $past(nvm_cfg);
	endsequence

	chk_bits_never_fall: assert property (@(posedge core_clk_in) disable iff (!rst_b)
		($past(nvm_flat) & ~nvm_flat) == 64'h0)
		else $error("store bit returned to zero");

	chk_global_lock_hold: assert property (@(posedge core_clk_in) disable iff (!rst_b)
		burn_take && nvm_q[7][0] |=> burn_refused_out && state_q == otp_store_pkg::st_idle)
		else $error("program accepted under global lock");

	chk_trim_lock_hold: assert property (@(posedge core_clk_in) disable iff (!rst_b)
		burn_take && nvm_q[7][1] && cmd_addr_in <= 3'h1
		|=> burn_refused_out && state_q == otp_store_pkg::st_idle && $stable(nvm_flat[15:0]))
		else $error("trim byte zapped under trim lock");

	chk_zap_sets_bits: assert property (@(posedge core_clk_in) disable iff (!rst_b)
		state_q == otp_store_pkg::st_zap && zap_cnt_q == 24'h000000
		|=> nvm_q[zap_addr_q] == ($past(nvm_q[zap_addr_q]) | zap_bits_q) && burn_done_out)
		else $error("zap result wrong");

	chk_read_pins: assert property (@(posedge core_clk_in) disable iff (!rst_b)
		s_fetch_taken ##0 cmd_addr_in == 3'h2 |=> rd_valid_out && rd_data_out[6:4] == $past(pin_id_bits))
		else $error("read of byte node_id_config lacks pin bits");

	chk_fetch_reloads: assert property (@(posedge core_clk_in) disable iff (!rst_b)
		s_fetch_taken |=> s_load_then_copy)
		else $error("read did not reload working ram");

	chk_node_id_form: assert property (@(posedge core_clk_in) disable iff (!rst_b)
		##1 node_id_out == ($past(id_swap_sel_q) ? {$past(prog_node_bits_q), $past(pin_id_bits)}
		: {$past(pin_id_bits), $past(prog_node_bits_q)}))
		else $error("node id formed wrongly");

	chk_standstill_current: assert property (@(posedge core_clk_in) disable iff (!rst_b)
		motor_stopped_in |=> coil_code_out == $past(ram_cfg_q.ihold))
		else $error("stopped motor not at standstill current");

	// a write cannot slip in mid-zap, so the ram must sit still until a load
	chk_zap_dormant: assert property (@(posedge core_clk_in) disable iff (!rst_b)
		state_q == otp_store_pkg::st_zap |=> $stable(ram_cfg_q))
		else $error("zapped bits reached ram before a load");

	chk_zap_only_blank: assert property (@(posedge core_clk_in) disable iff (!rst_b)
		burn_take && !locked |=> (zap_bits_q & $past(nvm_q[cmd_addr_in])) == 8'h00)
		else $error("zap aimed at a bit already set");

	chk_safe_disable: assert property (@(posedge core_clk_in) disable iff (!rst_b)
		ram_cfg_q.safe_target == 11'h400 |=> !safe_pos_en_out)
		else $error("secure positioning not disabled");

	chk_write_cfg: assert property (@(posedge core_clk_in) disable iff (!rst_b)
		cmd_take && cmd_op_in == otp_store_pkg::write_motion_cfg_cmd
		|=> ram_cfg_q == $past(cmd_cfg_in) && $stable(prog_node_bits_q) && $stable(nvm_flat))
		else $error("parameter write mishandled");
endmodule

// >>> otp_cmd_master.sv
// bus master model that hands parameter commands to the store one at a time
// assumes the store's ready only changes on rising edges of the shared clock
`timescale 1ns/1ns
module otp_cmd_master (
	// clock
	input  wire logic                   clk_in,
	// command port toward the store
	output logic                        cmd_valid_out,
	input  wire logic                   cmd_ready_in,
	output otp_store_pkg::cmd_op_t      cmd_op_out,
	output logic [2:0]                  cmd_addr_out,
	output logic [7:0]                  cmd_data_out,
	output otp_store_pkg::motion_cfg_t  cmd_cfg_out
);
	// idle request lines at time zero
	initial begin
		cmd_valid_out = 1'b0;
		cmd_op_out = otp_store_pkg::fetch_nvm_cmd;
		cmd_addr_out = 3'h0;
		cmd_data_out = 8'h00;
		cmd_cfg_out = '0;
	end

	// one whole byte per command; gap+1 idle cycles model a slow master
	task automatic send(input otp_store_pkg::cmd_op_t op, input logic [2:0] addr,
		input logic [7:0] data, input otp_store_pkg::motion_cfg_t cfg, input int gap);
		int n;
		for (n = 0; n <= gap; n++) @(negedge clk_in);
		cmd_valid_out = 1'b1;
		cmd_op_out = op;
		cmd_addr_out = addr;
		cmd_data_out = data;
		cmd_cfg_out = cfg;
		// ready seen here holds through the next rising edge, which takes it
		n = 0;
		while (cmd_ready_in !== 1'b1 && n < 500) begin
			@(negedge clk_in);
			n++;
		end
		@(negedge clk_in);
		cmd_valid_out = 1'b0;
		// released address, data and cfg fields carry no meaning, so never leave the old value there
		cmd_addr_out = ~addr;
		cmd_data_out = ~data;
		cmd_cfg_out = ~cfg;
	endtask
endmodule

// >>> test_otp_param_store.sv
// self-checking bench for the parameter store, driven through the master model
// assumes a short zap time parameter so each accepted program command takes 125 cycles
`timescale 1ns/1ns
module test_otp_param_store;
	logic                       core_clk_in;
	logic                       rst_b_in;
	logic                       cmd_valid;
	logic                       cmd_ready;
	otp_store_pkg::cmd_op_t     cmd_op;
	logic [2:0]                 cmd_addr;
	logic [7:0]                 cmd_data;
	otp_store_pkg::motion_cfg_t cmd_cfg;
	logic                       rd_valid_out;
	logic [7:0]                 rd_data_out;
	logic                       burn_refused_out;
	logic                       burn_done_out;
	logic [2:0]                 pins;
	logic                       stopped;
	otp_store_pkg::motion_cfg_t active_cfg;
	otp_store_pkg::motion_cfg_t c;
	logic [6:0]                 node_id;
	logic [3:0]                 coil_code;
	logic [9:0]                 coil_ma;
	logic                       safe_en;
	logic [3:0]                 clk_trim;
	logic [3:0]                 current_ref_trim_trim;
	logic [2:0]                 th_trim;
	logic [3:0]                 bg_trim;
	int                         bad_count;
	int                         comparisons;
	int                         seed = 32'h325a;
	int                         i;
	int                         k;
	logic [7:0]                 mem [8];
	logic [7:0]                 rd_q [$];
	logic [7:0]                 burn_q [$];
	logic [9:0]                 ma_tab [16] = '{10'h03b, 10'h047, 10'h054, 10'h064,
		10'h077, 10'h08d, 10'h0a8, 10'h0c8, 10'h0ee, 10'h11b, 10'h150, 10'h190,
		10'h1dc, 10'h236, 10'h2a1, 10'h320};

	otp_param_store #(.ZAP_TIME_US(1), .CAL_BYTE0(8'ha5), .CAL_BYTE1(8'h80)) dut (
		.core_clk_in(core_clk_in), .rst_b_in(rst_b_in),
		.cmd_valid_in(cmd_valid), .cmd_ready_out(cmd_ready), .cmd_op_in(cmd_op),
		.cmd_addr_in(cmd_addr), .cmd_data_in(cmd_data), .cmd_cfg_in(cmd_cfg),
		.rd_valid_out(rd_valid_out), .rd_data_out(rd_data_out),
		.burn_refused_out(burn_refused_out), .burn_done_out(burn_done_out),
		.pin_id_bits_in(pins), .motor_stopped_in(stopped), .active_cfg_out(active_cfg),
		.node_id_out(node_id), .coil_code_out(coil_code), .coil_ma_out(coil_ma),
		.safe_pos_en_out(safe_en), .clock_trim_out(clk_trim),
		.current_ref_trim_out(current_ref_trim_trim), .thermal_trim_out(th_trim),
		.bandgap_trim_out(bg_trim));

	otp_cmd_master master (
		.clk_in(core_clk_in), .cmd_valid_out(cmd_valid), .cmd_ready_in(cmd_ready),
		.cmd_op_out(cmd_op), .cmd_addr_out(cmd_addr), .cmd_data_out(cmd_data),
		.cmd_cfg_out(cmd_cfg));

	// 125 MHz core clock
	initial begin
		core_clk_in = 1'b0;
		forever #4 core_clk_in = ~core_clk_in;
	end

	task automatic check_read(input string name, input logic [7:0] exp, input logic [7:0] got);
		comparisons++;
		if (got !== exp) begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic check_port(input string name, input logic [33:0] exp,
		input logic [33:0] got);
		comparisons++;
		if (got !== exp) begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic print_verdict;
		if (bad_count == 0 && comparisons > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// watcher: every answer pulse takes the oldest note of its kind
	always @(negedge core_clk_in) begin
		if (rd_valid_out === 1'b1)
			check_read("read byte", rd_q.size() ? rd_q.pop_front() : 8'hxx, rd_data_out);
		if (burn_done_out === 1'b1 || burn_refused_out === 1'b1)
			check_read("burn outcome", burn_q.size() ? burn_q.pop_front() : 8'hxx,
				{6'h0, burn_refused_out, burn_done_out});
	end

	// the store's own view of what the ram should hold after a load
	function automatic otp_store_pkg::motion_cfg_t mem_cfg();
		return {mem[3], mem[4], mem[5][7:5], mem[6], mem[5][4:0], mem[7][3:2]};
	endfunction

	task automatic fetch(input logic [2:0] a);
		rd_q.push_back(a == 3'h2 ? ((mem[2] & 8'h8f) | {1'b0, pins, 4'h0}) : mem[a]);
		master.send(otp_store_pkg::fetch_nvm_cmd, a, 8'($random(seed)), cmd_cfg,
			$random(seed) & 3);
		repeat (4) @(negedge core_clk_in);
	endtask

	// locked bytes stay as they were; blank bits only ever turn to one
	task automatic burn(input logic [2:0] a, input logic [7:0] d);
		logic lk;
		int n;
		lk = mem[7][0] || (mem[7][1] && a <= 3'h1);
		burn_q.push_back(lk ? 8'h02 : 8'h01);
		if (!lk)
			mem[a] = mem[a] | (a == 3'h2 ? d & 8'h8f : d);
		master.send(otp_store_pkg::burn_byte_cmd, a, d, cmd_cfg, $random(seed) & 3);
		for (n = 0; n < 300 && cmd_ready !== 1'b1; n++) @(negedge core_clk_in);
		repeat (2) @(negedge core_clk_in);
	endtask

	// pins wander; the id follows them on the side the swap bit picks
	task automatic node_check();
		int j;
		for (j = 0; j < 4; j++) begin
			pins = 3'($random(seed));
			repeat (10) @(negedge core_clk_in);
			check_port("node id", mem[2][7] ? {mem[2][3:0], pins} : {pins, mem[2][3:0]},
				node_id);
		end
	endtask

	initial begin
		#160000;
		bad_count++;
		print_verdict();
	end

	initial begin
		rst_b_in = 1'b0;
		pins = 3'h5;
		stopped = 1'b0;
		mem = '{8'ha5, 8'h80, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02};
		repeat (5) @(negedge core_clk_in);
		rst_b_in = 1'b1;
		repeat (10) @(negedge core_clk_in);
		check_port("trims", {mem[0], mem[1][6:0]}, {clk_trim, current_ref_trim_trim, th_trim, bg_trim});
		for (i = 0; i < 8; i++) fetch(3'(i));
		burn(3'h0, 8'hff);
		burn(3'h1, 8'h7f);
		fetch(3'h0);
		fetch(3'h1);
		// newly zapped bits stay dormant until a load
		c = active_cfg;
		burn(3'h3, 8'($random(seed)));
		check_port("cfg before load", c, active_cfg);
		fetch(3'h3);
		check_port("cfg after load", mem_cfg(), active_cfg);
		for (i = 2; i < 7; i++) begin
			burn(3'(i), 8'($random(seed)) & (i == 2 ? 8'h7f : 8'hff));
			burn(3'(i), 8'($random(seed)) & (i == 2 ? 8'h7f : 8'hff));
			fetch(3'(i));
		end
		node_check();
		burn(3'h2, 8'h80);
		fetch(3'h2);
		node_check();
		// bus writes cover every code of current, resolution and direction
		for (k = 0; k < 16; k++) begin
			c = 34'({$random(seed), $random(seed)});
			c.irun = 4'(k);
			c.ihold = 4'(15 - k);
			c.microstep_res = otp_store_pkg::microstep_res_t'(k[1:0]);
			c.shaft = k[2];
			if (k == 5) c.safe_target = 11'h400;
			else if (c.safe_target == 11'h400) c.safe_target = 11'h401;
			stopped = k[0];
			master.send(otp_store_pkg::write_motion_cfg_cmd, 3'h0, 8'h00, c, k & 1);
			repeat (4) @(negedge core_clk_in);
			check_port("ram cfg", c, active_cfg);
			check_port("coil code", stopped ? c.ihold : c.irun, coil_code);
			check_port("coil ma", ma_tab[stopped ? c.ihold : c.irun], coil_ma);
			check_port("safe enable", k != 5, safe_en);
		end
		fetch(3'h4);
		master.send(otp_store_pkg::write_motion_cfg_cmd, 3'h0, 8'h00, ~mem_cfg(), 0);
		master.send(otp_store_pkg::restore_defaults_cmd, 3'h0, 8'h00, cmd_cfg, 1);
		repeat (4) @(negedge core_clk_in);
		check_port("restored cfg", mem_cfg(), active_cfg);
		burn(3'h7, 8'h01);
		fetch(3'h7);
		burn(3'h5, 8'hff);
		fetch(3'h5);
		repeat (5) @(negedge core_clk_in);
		check_port("notes left", 34'h0, 34'(rd_q.size() + burn_q.size()));
		print_verdict();
	end
endmodule
